// [aebs_pkg.sv]
// constants and carrier types for the acl entry byte-select register bank
package aebs_pkg;
	// direct register addresses on the byte-wide register port
	localparam logic [7:0] ADDR_IND_CTRL   = 8'h6e;
	localparam logic [7:0] ADDR_IND_OFFSET = 8'h6f;
	localparam logic [7:0] ADDR_IND_DATA   = 8'ha0;
	// indirect control register layout
	localparam int         TBL_SEL_MSB     = 7;
	localparam int         TBL_SEL_LSB     = 5;
	localparam int         PORT_MSB        = 3;
	localparam int         PORT_LSB        = 0;
	localparam logic [2:0] TBL_SEL_ACL     = 3'h2;
	// indirect offsets inside one acl port space
	localparam logic [7:0] OFS_MASK_HIGH   = 8'h10;
	localparam logic [7:0] OFS_MASK_LOW    = 8'h11;
	localparam logic [7:0] OFS_RW_CTRL     = 8'h12;
	// entry geometry
	localparam int         ENTRY_BYTES     = 14;
	localparam int         NUM_PORTS       = 5;
	localparam logic [3:0] FIRST_PORT      = 4'h1;
	localparam int         MASK_HIGH_BITS  = 6;
	// read/write control register layout
	localparam int         RW_WSTAT_BIT    = 6;
	localparam int         RW_RSTAT_BIT    = 5;
	localparam int         RW_DIR_BIT      = 4;
	localparam int         RW_ENTRY_MSB    = 3;
	// reset values
	localparam logic [7:0]  IND_CTRL_RST   = 8'h00;
	localparam logic [7:0]  IND_OFFSET_RST = 8'h00;
	localparam logic [13:0] MASK_RST       = 14'h0000;
	localparam logic [3:0]  ENTRY_RST      = 4'h0;
	localparam logic        STATUS_RST     = 1'b1;

	// one table transfer handed to the acl table
	typedef struct packed {
		logic        write;
		logic [3:0]  port;
		logic [3:0]  entry;
		logic [13:0] byte_sel;
	} aebs_tbl_cmd_type;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} aebs_state_type;
endpackage

// [aebs_byte_select.sv]
// acl entry byte-select mask bank with indirect access and transfer completion flags
// Behaviour
// - holds a 14-bit byte-select mask, one bit per acl entry byte
// - a one selects its byte for read or write, a zero leaves it untouched
// - mask bit 0 maps entry byte 0x0d, bit 13 maps entry byte 0x00
// - the selected indirect byte is read and written through data register 0xa0
// - write completion flag is zero while a table write runs, one after
// - read completion flag is zero while a table read runs, one after
`timescale 1ns/1ps
`default_nettype none
module aebs_byte_select
	import aebs_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [7:0]                      reg_rdata,
	output logic                            tbl_req,
	output aebs_pkg::aebs_tbl_cmd_type      tbl_cmd,
	input  wire logic                       tbl_done
);
	import aebs_pkg::*;

	logic [7:0]                      ind_ctrl;
	logic [7:0]                      ind_offset;
	logic [NUM_PORTS-1:0][13:0]      masks;
	logic [3:0]                      rw_entry;
	logic                            rw_dir;
	logic                            write_status;
	logic                            read_status;
	aebs_state_type                  state;
	logic                            acl_sel;
	logic [3:0]                      port_idx;
	logic                            data_wr;
	logic                            data_rd;
	logic                            mask_hi_wr;
	logic                            mask_lo_wr;
	logic                            start;
	logic [13:0]                     cur_mask;
	logic [7:0]                      next_rdata;

	// decode of the indirect selection; ports 1..5 map onto slots 0..4
	assign acl_sel  = (ind_ctrl[TBL_SEL_MSB:TBL_SEL_LSB] == TBL_SEL_ACL)
		&& (ind_ctrl[PORT_MSB:PORT_LSB] >= FIRST_PORT)
		&& (ind_ctrl[PORT_MSB:PORT_LSB] < FIRST_PORT + 4'(NUM_PORTS));
	assign port_idx = ind_ctrl[PORT_MSB:PORT_LSB] - FIRST_PORT;
	assign cur_mask = acl_sel ? masks[port_idx[2:0]] : MASK_RST;
	assign data_wr  = reg_wr && (reg_addr == ADDR_IND_DATA) && acl_sel;
	assign data_rd  = reg_rd && (reg_addr == ADDR_IND_DATA) && acl_sel;
	// mask writes during a transfer are dropped so the table never sees a torn mask
	assign mask_hi_wr = data_wr && (ind_offset == OFS_MASK_HIGH) && (state == ST_IDLE);
	assign mask_lo_wr = data_wr && (ind_offset == OFS_MASK_LOW) && (state == ST_IDLE);
	assign start      = data_wr && (ind_offset == OFS_RW_CTRL) && (state == ST_IDLE);

	// direct registers: indirect control and offset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ind_ctrl   <= IND_CTRL_RST;
			ind_offset <= IND_OFFSET_RST;
		end
		else if (reg_wr && reg_addr == ADDR_IND_CTRL)
			ind_ctrl   <= reg_wdata;
		else if (reg_wr && reg_addr == ADDR_IND_OFFSET)
			ind_offset <= reg_wdata;
	end

	// per-port byte-select masks; bits 7:6 of the high byte are reserved
	always_ff @(posedge clock)
	begin
		if (rst)
			masks <= {NUM_PORTS{MASK_RST}};
		else if (mask_hi_wr)
			masks[port_idx[2:0]][13:8] <= reg_wdata[MASK_HIGH_BITS-1:0];
		else if (mask_lo_wr)
			masks[port_idx[2:0]][7:0] <= reg_wdata;
	end

	// read/write control fields latched when a transfer is launched
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rw_entry <= ENTRY_RST;
			rw_dir   <= 1'b0;
		end
		else if (start)
		begin
			rw_entry <= reg_wdata[RW_ENTRY_MSB:0];
			rw_dir   <= reg_wdata[RW_DIR_BIT];
		end
	end

	// transfer sequencer: one request cycle, then wait for the table
	always_ff @(posedge clock)
	begin
		if (rst)
			state <= ST_IDLE;
		else
			case (state)
				ST_IDLE:  if (start) state <= ST_ISSUE;
				ST_ISSUE: state <= ST_WAIT;
				ST_WAIT:  if (tbl_done) state <= ST_IDLE;
				default:  state <= ST_IDLE;
			endcase
	end

	// the completion flag of the launched direction drops at launch; both flags rise when the table answers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			write_status <= STATUS_RST;
			read_status  <= STATUS_RST;
		end
		else if (start)
		begin
			write_status <= !reg_wdata[RW_DIR_BIT];
			read_status  <= reg_wdata[RW_DIR_BIT];
		end
		else if (state == ST_WAIT && tbl_done)
		begin
			write_status <= 1'b1;
			read_status  <= 1'b1;
		end
	end

	// table command; the mask is reversed so bit 0 lands on entry byte 0x0d
	always_ff @(posedge clock)
	begin
		if (rst)
			tbl_cmd <= '0;
		else if (start)
		begin
			tbl_cmd.write    <= reg_wdata[RW_DIR_BIT];
			tbl_cmd.port     <= ind_ctrl[PORT_MSB:PORT_LSB];
			tbl_cmd.entry    <= reg_wdata[RW_ENTRY_MSB:0];
			tbl_cmd.byte_sel <= {<<{cur_mask}};
		end
	end

	assign tbl_req = (state == ST_ISSUE);

	// read mux for the byte register port; unmapped reads return zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_addr == ADDR_IND_CTRL)
			next_rdata = ind_ctrl;
		else if (reg_addr == ADDR_IND_OFFSET)
			next_rdata = ind_offset;
		else if (data_rd)
			case (ind_offset)
				OFS_MASK_HIGH: next_rdata = {2'b00, cur_mask[13:8]};
				OFS_MASK_LOW:  next_rdata = cur_mask[7:0];
				OFS_RW_CTRL:   next_rdata = {1'b0, write_status, read_status, rw_dir, rw_entry};
				default:       next_rdata = 8'h00;
			endcase
	end

	// read data is registered, valid the cycle after reg_rd
	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// checks
	sequence s_launch_write;
		start && reg_wdata[RW_DIR_BIT];
	endsequence

	sequence s_launch_read;
		start && !reg_wdata[RW_DIR_BIT];
	endsequence

	// a write holds its flag low through the request cycle and into the wait
	sequence s_write_pending_issue;
		!write_status && read_status && tbl_req;
	endsequence

	sequence s_write_pending_wait;
		!write_status && read_status && state == ST_WAIT;
	endsequence

	a_mask_only_by_data: assert property (@(posedge clock) disable iff (rst)
		$changed(masks) |-> $past(mask_hi_wr || mask_lo_wr))
		else $error("byte-select mask changed without a data register write");

	a_sel_polarity: assert property (@(posedge clock) disable iff (rst)
		start |=> $countones(tbl_cmd.byte_sel) == $countones($past(cur_mask)))
		else $error("byte select does not follow mask polarity");

	a_sel_reverse_map: assert property (@(posedge clock) disable iff (rst)
		start |=> tbl_cmd.byte_sel[13] == $past(cur_mask[0])
			&& tbl_cmd.byte_sel[0] == $past(cur_mask[13]))
		else $error("mask bit 0 not mapped to entry byte 0x0d");

	a_data_low_rw: assert property (@(posedge clock) disable iff (rst)
		mask_lo_wr ##1 (reg_rd && reg_addr == ADDR_IND_DATA && acl_sel
			&& ind_offset == OFS_MASK_LOW && $stable(ind_ctrl))
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("low mask byte does not read back through data register");

	a_write_in_flight: assert property (@(posedge clock) disable iff (rst)
		s_launch_write |=> s_write_pending_issue ##1 s_write_pending_wait)
		else $error("write completion flag wrong during write");

	a_write_busy: assert property (@(posedge clock) disable iff (rst)
		(state != ST_IDLE && tbl_cmd.write) |-> !write_status)
		else $error("write completion flag high while write in progress");

	a_write_done: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WAIT && tbl_cmd.write && tbl_done) |=> write_status && state == ST_IDLE)
		else $error("write completion flag not set after write finished");

	a_read_launch: assert property (@(posedge clock) disable iff (rst)
		s_launch_read |=> !read_status && write_status && tbl_req ##1 !tbl_req)
		else $error("read launch did not clear read flag and issue one request");

	a_read_done: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WAIT && !tbl_cmd.write && tbl_done) |=> read_status)
		else $error("read completion flag not set after read finished");
endmodule
`default_nettype wire

// [aebs_byte_select_bench.sv]
// self-checking bench for the acl entry byte-select register bank
`timescale 1ns/1ps
`default_nettype none
module aebs_byte_select_bench;
	import aebs_pkg::*;
	logic              clock;
	logic              rst;
	logic [7:0]        reg_addr;
	logic [7:0]        reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [7:0]        reg_rdata;
	logic              tbl_req;
	aebs_tbl_cmd_type  tbl_cmd;
	logic              tbl_done;
	int                bad_count;
	int                samples_checked;

	aebs_byte_select u_aebs_byte_select (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tbl_req(tbl_req), .tbl_cmd(tbl_cmd), .tbl_done(tbl_done));

	// 40 mhz clock
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// byte compare
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// table command compare
	task automatic chk_cmd(input aebs_tbl_cmd_type got, input aebs_tbl_cmd_type exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// mask bit i lands on entry byte 13-i
	function automatic logic [13:0] rev(input logic [13:0] m);
		logic [13:0] r;
		for (int k = 0; k < 14; k++)
			r[k] = m[13-k];
		return r;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data is registered, so it is looked at on the falling edge after the edge that samples the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk8(reg_rdata, exp);
	endtask

	// write then read the same address on the next cycle, no idle cycle between
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk8(reg_rdata, exp);
	endtask

	task automatic ind_wr(input logic [7:0] o, input logic [7:0] d);
		wr(ADDR_IND_OFFSET, o);
		wr(ADDR_IND_DATA, d);
	endtask

	task automatic ind_rd(input logic [7:0] o, input logic [7:0] exp);
		wr(ADDR_IND_OFFSET, o);
		rd(ADDR_IND_DATA, exp);
	endtask

	// launch a transfer and watch the one-cycle request
	task automatic launch(input logic [7:0] d, input aebs_tbl_cmd_type exp);
		ind_wr(OFS_RW_CTRL, d);
		@(negedge clock);
		chk8({7'h00, tbl_req}, 8'h01);
		chk_cmd(tbl_cmd, exp);
		@(negedge clock);
		chk8({7'h00, tbl_req}, 8'h00);
	endtask

	task automatic finish_xfer();
		@(posedge clock);
		tbl_done <= 1'b1;
		@(posedge clock);
		tbl_done <= 1'b0;
	endtask

	task automatic t_reset();
		wr(ADDR_IND_CTRL, 8'h41);
		ind_rd(OFS_MASK_LOW, 8'h00);
		ind_rd(OFS_MASK_HIGH, 8'h00);
		ind_rd(OFS_RW_CTRL, 8'h60);
		$display("test reset done");
	endtask

	task automatic t_write();
		wr(ADDR_IND_OFFSET, OFS_MASK_LOW);
		wr_rd(ADDR_IND_DATA, 8'hab, 8'hab);
		ind_wr(OFS_MASK_HIGH, 8'hff);
		ind_rd(OFS_MASK_HIGH, 8'h3f);
		ind_rd(OFS_MASK_LOW, 8'hab);
		launch(8'h13, '{1'b1, 4'h1, 4'h3, rev(14'h3fab)});
		ind_rd(OFS_RW_CTRL, 8'h33);
		ind_wr(OFS_MASK_LOW, 8'h00);
		finish_xfer();
		ind_rd(OFS_RW_CTRL, 8'h73);
		ind_rd(OFS_MASK_LOW, 8'hab);
		$display("test write done");
	endtask

	task automatic t_read();
		wr(ADDR_IND_CTRL, 8'h45);
		ind_wr(OFS_MASK_HIGH, 8'h00);
		ind_wr(OFS_MASK_LOW, 8'h01);
		launch(8'h05, '{1'b0, 4'h5, 4'h5, 14'h2000});
		ind_rd(OFS_RW_CTRL, 8'h45);
		finish_xfer();
		ind_rd(OFS_RW_CTRL, 8'h65);
		$display("test read done");
	endtask

	// a wrong table code must leave the masks alone, and an unmapped port must read the mask as zero
	task automatic t_refuse();
		wr(ADDR_IND_CTRL, 8'h21);
		ind_wr(OFS_MASK_LOW, 8'h55);
		ind_rd(OFS_MASK_LOW, 8'h00);
		wr(ADDR_IND_CTRL, 8'h40);
		ind_rd(OFS_MASK_LOW, 8'h00);
		wr(ADDR_IND_CTRL, 8'h41);
		ind_rd(OFS_MASK_LOW, 8'hab);
		$display("test refuse done");
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog, well beyond the roughly 110 cycles the tests need
	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		conclude();
	end

	initial
	begin
		bad_count = 0;
		samples_checked = 0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tbl_done = 1'b0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_write();
		t_read();
		t_refuse();
		conclude();
	end
endmodule
`default_nettype wire
